// ==== logic/pdsc_ctrl.v ====
// Power-domain gating and sleep-mode controller
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "pdsc_consts.vh"
module pdsc_ctrl #(
  parameter SETTLE_CYC = `PDSC_SETTLE_CYC,
  parameter NRR = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [`PDSC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire core_sleeping,
  input wire wake_event,
  input wire reset_pad,
  output reg always_on_domain,
  output reg system_domain,
  output reg peripheral_domain,
  output reg debug_domain,
  output reg radio_domain,
  output reg [NRR-1:0] retention_mem_domain,
  output reg system_ram_domain,
  output reg sysram_access_en,
  output reg analog_en,
  output reg core_run,
  output reg otp_copy_req,
  output reg hw_reset
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_ACTIVE = 3'd0;
  localparam [2:0] ST_SLEEP = 3'd1;
  localparam [2:0] ST_XSLEEP = 3'd2;
  localparam [2:0] ST_WAKE_AN = 3'd3;
  localparam [2:0] ST_WAKE_PD = 3'd4;

  localparam CNT_W = 16;
  // Last count of a settle span, cut to the counter width on purpose
  localparam [31:0] SETTLE_LAST_W = SETTLE_CYC - 1;
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_W[CNT_W-1:0];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire wake_s;
  wire pad_s;
  pdsc_sync2 #(.WIDTH(2)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({wake_event, reset_pad}),
    .sync_out({wake_s, pad_s})
  );

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg [31:0] sys_ctrl_r;
  reg [31:0] pwr_en_r;
  reg scr_deep_r;
  reg [31:0] wake_reg_r;

  // Reset pad high means reset; combined with the core reset
  wire rst_int_b = rst_b & ~pad_s;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function is_addr;
    input [`PDSC_ADDR_W-1:0] a;
    input [`PDSC_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  wire wr_sys = reg_wr & is_addr(reg_addr, `PDSC_OFS_SYS_CTRL);
  wire wr_pwr = reg_wr & is_addr(reg_addr, `PDSC_OFS_PWR_EN);
  wire wr_scr = reg_wr & is_addr(reg_addr, `PDSC_OFS_CORE_SCR);
  wire wr_radio = reg_wr & is_addr(reg_addr, `PDSC_OFS_RADIO_CTRL);
  wire wr_dbg = reg_wr & is_addr(reg_addr, `PDSC_OFS_DEBUG);
  wire wr_otp = reg_wr & is_addr(reg_addr, `PDSC_OFS_OTP_NWORDS);
  wire wr_gp = reg_wr & is_addr(reg_addr, `PDSC_OFS_GP_CTRL);
  wire wr_wake = reg_wr & is_addr(reg_addr, `PDSC_OFS_WAKE);

  // System domain dropping clears its unretained register content
  wire sys_off_pulse = (state_r == ST_ACTIVE || state_r == ST_SLEEP) && (state_nxt == ST_XSLEEP);

  // ----------------------------------------
  // Retained registers
  // ----------------------------------------
  wire [31:0] radio_ctrl_q;
  wire [31:0] dbg_q;
  wire [31:0] otp_q;
  wire [31:0] gp_q;

  pdsc_retreg #(.WIDTH(32), .RST_VAL(`PDSC_RST_RADIO_CTRL),
    .KEEP_MASK(`PDSC_RADIO_KEEP_MASK)) u_radio (
    .ref_clk(ref_clk), .rst_b(rst_int_b), .wr_en(wr_radio),
    .wr_data(reg_wdata), .sleep_clr(sys_off_pulse), .value_r(radio_ctrl_q)
  );
  pdsc_retreg #(.WIDTH(32), .RST_VAL(`PDSC_RST_DEBUG),
    .KEEP_MASK(`PDSC_DEBUG_KEEP_MASK)) u_dbg (
    .ref_clk(ref_clk), .rst_b(rst_int_b), .wr_en(wr_dbg),
    .wr_data(reg_wdata), .sleep_clr(sys_off_pulse), .value_r(dbg_q)
  );
  pdsc_retreg #(.WIDTH(32), .RST_VAL(`PDSC_RST_OTP_NWORDS),
    .KEEP_MASK(`PDSC_OTP_KEEP_MASK)) u_otp (
    .ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_otp),
    .wr_data(reg_wdata), .sleep_clr(sys_off_pulse), .value_r(otp_q)
  );
  pdsc_retreg #(.WIDTH(32), .RST_VAL(`PDSC_RST_GP_CTRL),
    .KEEP_MASK(`PDSC_GP_KEEP_MASK)) u_gp (
    .ref_clk(ref_clk), .rst_b(rst_int_b), .wr_en(wr_gp),
    .wr_data(reg_wdata), .sleep_clr(sys_off_pulse), .value_r(gp_q)
  );

  // ----------------------------------------
  // Control and always-on registers
  // ----------------------------------------
  // Control and enable registers live on always-on power and keep state
  always @(posedge ref_clk) begin
    if (!rst_int_b) begin
      sys_ctrl_r <= `PDSC_RST_SYS_CTRL;
      pwr_en_r <= `PDSC_RST_PWR_EN;
      scr_deep_r <= 1'b0;
      wake_reg_r <= `PDSC_RST_WAKE;
    end else begin
      if (wr_sys) begin
        sys_ctrl_r <= reg_wdata & 32'h0000_0001;
      end
      if (wr_pwr) begin
        pwr_en_r <= reg_wdata & 32'h0000_003f;
      end
      if (wr_wake) begin
        wake_reg_r <= reg_wdata;
      end
      // Deep-sleep bit belongs to the core; it clears on core release
      if (wr_scr) begin
        scr_deep_r <= reg_wdata[`PDSC_SCR_DEEP];
      end else if (state_r == ST_WAKE_PD && cnt_r == SETTLE_LAST) begin
        scr_deep_r <= 1'b0;
      end
    end
  end

  // Extended sleep needs both retain bit and deep-sleep bit set
  wire xsleep_req = sys_ctrl_r[`PDSC_SYS_RETAIN_RAM] & scr_deep_r;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_ACTIVE: begin
        if (core_sleeping && xsleep_req) begin
          state_nxt = ST_XSLEEP;
        end else if (core_sleeping) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_s || !core_sleeping) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_XSLEEP: begin
        if (wake_s) begin
          state_nxt = ST_WAKE_AN;
          cnt_nxt = {CNT_W{1'b0}};
        end
      end
      // Analog first, then domains, then core: rails must be up first
      ST_WAKE_AN: begin
        if (cnt_r == SETTLE_LAST) begin
          state_nxt = ST_WAKE_PD;
          cnt_nxt = {CNT_W{1'b0}};
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_WAKE_PD: begin
        if (cnt_r == SETTLE_LAST) begin
          state_nxt = ST_ACTIVE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_int_b) begin
      state_r <= ST_ACTIVE;
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Domain switch outputs
  // ----------------------------------------
  wire in_xs = (state_nxt == ST_XSLEEP) || (state_nxt == ST_WAKE_AN);
  wire pd_up = (state_nxt == ST_ACTIVE) || (state_nxt == ST_SLEEP) ||
               (state_nxt == ST_WAKE_PD);

  always @(posedge ref_clk) begin
    if (!rst_int_b) begin
      always_on_domain <= 1'b1;
      system_domain <= 1'b1;
      peripheral_domain <= 1'b1;
      debug_domain <= 1'b1;
      radio_domain <= 1'b1;
      retention_mem_domain <= {NRR{1'b0}};
      system_ram_domain <= 1'b1;
      sysram_access_en <= 1'b1;
      analog_en <= 1'b1;
      core_run <= 1'b1;
      otp_copy_req <= 1'b0;
    end else begin
      always_on_domain <= 1'b1;
      system_domain <= pd_up;
      debug_domain <= pd_up;
      // Peripheral and radio follow software enables, but are forced off in extended sleep and in the analog wake step
      peripheral_domain <= pwr_en_r[`PDSC_PWR_PER] & ~in_xs;
      radio_domain <= pwr_en_r[`PDSC_PWR_RAD] & ~in_xs;
      retention_mem_domain <= pwr_en_r[`PDSC_PWR_RR_HI:`PDSC_PWR_RR_LO];
      system_ram_domain <= 1'b1;
      sysram_access_en <= pd_up && !in_xs;
      analog_en <= !(state_nxt == ST_XSLEEP);
      core_run <= (state_nxt == ST_ACTIVE) || (state_nxt == ST_SLEEP);
      // RAM contents were kept, so no mirroring on this wake
      otp_copy_req <= 1'b0;
    end
  end

  // Reset pad observed as an active-high internal reset
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      hw_reset <= 1'b0;
    end else begin
      hw_reset <= pad_s;
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (is_addr(reg_addr, `PDSC_OFS_SYS_CTRL)) begin
        reg_rdata <= sys_ctrl_r;
      end else if (is_addr(reg_addr, `PDSC_OFS_PWR_EN)) begin
        reg_rdata <= pwr_en_r;
      end else if (is_addr(reg_addr, `PDSC_OFS_CORE_SCR)) begin
        reg_rdata <= {29'h0000_0000, scr_deep_r, 2'b00};
      end else if (is_addr(reg_addr, `PDSC_OFS_STATUS)) begin
        reg_rdata <= {23'h00_0000, analog_en, system_domain, debug_domain, radio_domain,
          peripheral_domain, system_ram_domain, state_r};
      end else if (is_addr(reg_addr, `PDSC_OFS_RADIO_CTRL)) begin
        reg_rdata <= radio_ctrl_q;
      end else if (is_addr(reg_addr, `PDSC_OFS_DEBUG)) begin
        reg_rdata <= dbg_q;
      end else if (is_addr(reg_addr, `PDSC_OFS_OTP_NWORDS)) begin
        reg_rdata <= otp_q;
      end else if (is_addr(reg_addr, `PDSC_OFS_GP_CTRL)) begin
        reg_rdata <= gp_q;
      end else if (is_addr(reg_addr, `PDSC_OFS_WAKE)) begin
        reg_rdata <= wake_reg_r;
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // pdsc_ctrl

// ==== logic/pdsc_consts.vh ====
// Register offsets, field positions, reset values and timing counts for the sleep controller
`ifndef PDSC_CONSTS_VH
`define PDSC_CONSTS_VH

// ----------------------------------------
// Register offsets (word addressed)
// ----------------------------------------
`define PDSC_ADDR_W 4
`define PDSC_OFS_SYS_CTRL 4'h0
`define PDSC_OFS_PWR_EN 4'h1
`define PDSC_OFS_CORE_SCR 4'h2
`define PDSC_OFS_STATUS 4'h3
`define PDSC_OFS_RADIO_CTRL 4'h4
`define PDSC_OFS_DEBUG 4'h5
`define PDSC_OFS_OTP_NWORDS 4'h6
`define PDSC_OFS_GP_CTRL 4'h7
`define PDSC_OFS_WAKE 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDSC_SYS_RETAIN_RAM 0
`define PDSC_PWR_PER 0
`define PDSC_PWR_RAD 1
`define PDSC_PWR_RR_LO 2
`define PDSC_PWR_RR_HI 5
`define PDSC_SCR_DEEP 2
`define PDSC_DBG_FREEZE 0
`define PDSC_GP_EMMAP_LO 0
`define PDSC_GP_EMMAP_HI 2
`define PDSC_WAKE_REQ 0

// ----------------------------------------
// Reset values and retention masks
// ----------------------------------------
`define PDSC_RST_SYS_CTRL 32'h0000_0000
`define PDSC_RST_PWR_EN 32'h0000_0003
`define PDSC_RST_RADIO_CTRL 32'h0000_0000
`define PDSC_RST_GP_CTRL 32'h0000_0000
`define PDSC_RST_OTP_NWORDS 32'h0000_0000
`define PDSC_RST_DEBUG 32'h0000_0000
`define PDSC_RST_WAKE 32'h0000_0000
`define PDSC_DEBUG_KEEP_MASK 32'h0000_0001
`define PDSC_OTP_KEEP_MASK 32'hffff_ffff
`define PDSC_RADIO_KEEP_MASK 32'h0000_ffff
`define PDSC_GP_KEEP_MASK 32'h0000_0007

// ----------------------------------------
// Timing
// ----------------------------------------
`define PDSC_CLK_MHZ 250
`define PDSC_SETTLE_NS 100
`define PDSC_SETTLE_CYC ((`PDSC_SETTLE_NS * `PDSC_CLK_MHZ + 999) / 1000)

`endif

// ==== logic/pdsc_sync2.v ====
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pdsc_sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // pdsc_sync2

// ==== logic/pdsc_retreg.v ====
// Register whose masked fields survive the sleep clear
`timescale 1ns/100ps
module pdsc_retreg #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] KEEP_MASK = {WIDTH{1'b1}}
) (
  input wire ref_clk,
  input wire rst_b,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire sleep_clr,
  output reg [WIDTH-1:0] value_r
);
  // Domain power loss clears the unretained bits only
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      value_r <= RST_VAL;
    end else if (wr_en) begin
      value_r <= wr_data;
    end else if (sleep_clr) begin
      value_r <= (value_r & KEEP_MASK) | (RST_VAL & ~KEEP_MASK);
    end
  end
endmodule // pdsc_retreg

// ==== bench/pdsc_ctrl_asserts.sv ====
// Port-level checks of the sleep controller, bound to its top module
`timescale 1ns/100ps
`include "pdsc_consts.vh"
module pdsc_ctrl_chk #(
  parameter SETTLE_CYC = 2
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [`PDSC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire core_sleeping,
  input wire reset_pad,
  input wire always_on_domain,
  input wire system_domain,
  input wire peripheral_domain,
  input wire debug_domain,
  input wire radio_domain,
  input wire system_ram_domain,
  input wire sysram_access_en,
  input wire analog_en,
  input wire core_run,
  input wire otp_copy_req,
  input wire hw_reset
);
  // Generous bound: sync stages plus two settle spans
  localparam int WAKE_MAX = 2 * SETTLE_CYC + 8;
  reg deep_r;
  reg ret_r;
  reg run_d_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Shadow of the software sleep request
  // ----------------------------------------
  // Deep bit dropped once the core is released again
  always @(posedge ref_clk) begin
    run_d_r <= core_run;
    if (!rst_b || hw_reset) begin
      deep_r <= 1'b0;
      ret_r <= 1'b0;
    end else if (reg_wr && reg_addr == `PDSC_OFS_CORE_SCR) begin
      deep_r <= reg_wdata[`PDSC_SCR_DEEP];
    end else if (reg_wr && reg_addr == `PDSC_OFS_SYS_CTRL) begin
      ret_r <= reg_wdata[`PDSC_SYS_RETAIN_RAM];
    end else if (core_run && !run_d_r) begin
      deep_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_aon; always_on_domain; endproperty
  a_aon: assert property (p_aon) else $error("always-on domain dropped");
  property p_run_sys; core_run |-> system_domain && debug_domain && sysram_access_en; endproperty
  a_run_sys: assert property (p_run_sys) else $error("core runs unpowered");
  property p_sr; system_ram_domain; endproperty
  a_sr: assert property (p_sr) else $error("system RAM domain dropped");
  property p_xs_off;
    !analog_en |-> !(system_domain | debug_domain | peripheral_domain | radio_domain
      | sysram_access_en | core_run);
  endproperty
  a_xs_off: assert property (p_xs_off) else $error("domain on in extended sleep");
  property p_plain;
    core_sleeping && !deep_r && run_d_r && core_run |=> system_domain && core_run && analog_en;
  endproperty
  a_plain: assert property (p_plain) else $error("plain sleep gated power");
  property p_enter;
    core_sleeping && deep_r && ret_r && run_d_r && core_run && !reset_pad && !hw_reset
      |-> ##[1:2] !analog_en && !system_domain && !debug_domain;
  endproperty
  a_enter: assert property (p_enter) else $error("extended sleep not entered");
  property p_otp; !otp_copy_req; endproperty
  a_otp: assert property (p_otp) else $error("copy requested");
  property p_wake; $rose(analog_en) |-> ##[1:WAKE_MAX] core_run; endproperty
  a_wake: assert property (p_wake) else $error("core not released after wake");
  property p_pad_hi; reset_pad [*4] |-> hw_reset; endproperty
  a_pad_hi: assert property (p_pad_hi) else $error("pad high ignored");
  property p_pad_lo; !reset_pad [*4] |-> !hw_reset; endproperty
  a_pad_lo: assert property (p_pad_lo) else $error("pad low resets");
  c_enter: cover property ($fell(analog_en));
  c_wake: cover property ($rose(core_run));
  c_pad: cover property ($rose(hw_reset));
endmodule // pdsc_ctrl_chk

bind pdsc_ctrl pdsc_ctrl_chk #(.SETTLE_CYC(SETTLE_CYC)) i_chk (.ref_clk(ref_clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .core_sleeping(core_sleeping), .reset_pad(reset_pad), .always_on_domain(always_on_domain),
  .system_domain(system_domain), .peripheral_domain(peripheral_domain),
  .debug_domain(debug_domain), .radio_domain(radio_domain),
  .system_ram_domain(system_ram_domain), .sysram_access_en(sysram_access_en),
  .analog_en(analog_en), .core_run(core_run), .otp_copy_req(otp_copy_req),
  .hw_reset(hw_reset));

// ==== bench/testbench.sv ====
// Self-checking bench for the sleep controller
`timescale 1ns/100ps
`include "pdsc_consts.vh"
module testbench;
  // Small settle count keeps wake short
  localparam SETTLE = 2;
  // Writable and retained masks of registers 4..8, highest listed first
  localparam [159:0] WM = {32'hffff_ffff, 32'h0000_0007, 32'hffff_ffff, 32'h0000_0001,
    32'hffff_ffff};
  localparam [159:0] KM = {32'hffff_ffff, 32'h0000_0007, 32'hffff_ffff, 32'h0000_0001,
    32'h0000_ffff};
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [`PDSC_ADDR_W-1:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg core_sleeping = 1'b0;
  reg wake_event = 1'b0;
  reg reset_pad = 1'b0;
  reg rd_pend = 1'b0;
  wire [31:0] reg_rdata;
  wire always_on_domain, system_domain, peripheral_domain, debug_domain, radio_domain;
  wire [3:0] retention_mem_domain;
  wire system_ram_domain, sysram_access_en, analog_en, core_run, otp_copy_req, hw_reset;
  integer mismatches = 0;
  integer check_count = 0;
  integer i;
  reg [31:0] seed = 32'd92559;
  reg [31:0] val [4:8];
  reg [31:0] exp_q [$];

  pdsc_ctrl #(.SETTLE_CYC(SETTLE), .NRR(4)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_sleeping(core_sleeping), .wake_event(wake_event),
    .reset_pad(reset_pad), .always_on_domain(always_on_domain),
    .system_domain(system_domain), .peripheral_domain(peripheral_domain),
    .debug_domain(debug_domain), .radio_domain(radio_domain),
    .retention_mem_domain(retention_mem_domain), .system_ram_domain(system_ram_domain),
    .sysram_access_en(sysram_access_en), .analog_en(analog_en), .core_run(core_run),
    .otp_copy_req(otp_copy_req), .hw_reset(hw_reset));

  // 4 ns clock
  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Read strobe; the expectation waits in the queue for the monitor
  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
    end
  endtask

  // Two falling edges let registered outputs settle; returns on a rising edge
  task dom(input sy, input db, input pe, input ra, input [3:0] rr, input ac, input an,
    input run, input hr);
    begin
      repeat (2) @(negedge ref_clk);
      check({always_on_domain, system_domain, debug_domain,
        peripheral_domain, radio_domain, retention_mem_domain, system_ram_domain,
        sysram_access_en, analog_en, core_run, otp_copy_req, hw_reset},
        {1'b1, sy, db, pe, ra, rr, 1'b1, ac, an, run, 1'b0, hr});
      // Later stimulus then lands by non-blocking assignment on a rising edge
      @(posedge ref_clk);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_pend)
      check(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  task complete_run;
    begin
      $display("mismatches %0d check_count %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #80000;
    mismatches = mismatches + 1;
    complete_run;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    dom(1, 1, 1, 1, 4'h0, 1, 1, 1, 0);
    rd(`PDSC_OFS_PWR_EN, 32'h0000_0003);
    rd(`PDSC_OFS_STATUS, 32'h0000_01f8);
    for (i = 9; i < 16; i = i + 1) begin
      wr(i[3:0], 32'hffff_ffff);
      rd(i[3:0], 32'h0000_0000);
    end
    // Random enables reach the switched domains directly
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr_next(seed);
      wr(`PDSC_OFS_PWR_EN, {26'h0, seed[5:0]});
      dom(1, 1, seed[0], seed[1], seed[5:2], 1, 1, 1, 0);
    end
    for (i = 4; i < 9; i = i + 1) begin
      seed = lfsr_next(seed);
      val[i] = seed & WM[(i-4)*32 +: 32];
      wr(i[3:0], val[i]);
      rd(i[3:0], val[i]);
    end
    // Plain sleep must leave every domain as programmed
    wr(`PDSC_OFS_PWR_EN, 32'h0000_0003);
    core_sleeping <= 1'b1;
    dom(1, 1, 1, 1, 4'h0, 1, 1, 1, 0);
    core_sleeping <= 1'b0;
    // Software first lowers peripheral and radio, keeps two retention blocks
    wr(`PDSC_OFS_PWR_EN, 32'h0000_0014);
    wr(`PDSC_OFS_SYS_CTRL, 32'h0000_0001);
    wr(`PDSC_OFS_CORE_SCR, 32'h0000_0004);
    core_sleeping <= 1'b1;
    dom(0, 0, 0, 0, 4'h5, 0, 0, 0, 0);
    repeat (20) @(posedge ref_clk);
    dom(0, 0, 0, 0, 4'h5, 0, 0, 0, 0);
    wake_event <= 1'b1;
    for (i = 0; i < 300 && core_run !== 1'b1; i = i + 1)
      @(posedge ref_clk);
    core_sleeping <= 1'b0;
    wake_event <= 1'b0;
    dom(1, 1, 0, 0, 4'h5, 1, 1, 1, 0);
    for (i = 4; i < 9; i = i + 1)
      rd(i[3:0], val[i] & KM[(i-4)*32 +: 32]);
    rd(`PDSC_OFS_CORE_SCR, 32'h0000_0000);
    // Pad held high resets everything but the copy word count
    reset_pad <= 1'b1;
    repeat (5) @(posedge ref_clk);
    dom(1, 1, 1, 1, 4'h0, 1, 1, 1, 1);
    reset_pad <= 1'b0;
    repeat (5) @(posedge ref_clk);
    dom(1, 1, 1, 1, 4'h0, 1, 1, 1, 0);
    rd(`PDSC_OFS_RADIO_CTRL, 32'h0000_0000);
    rd(`PDSC_OFS_OTP_NWORDS, val[6]);
    repeat (3) @(posedge ref_clk);
    complete_run;
  end
endmodule // testbench
